/* File: ire_bus_model.sv */
// Behavioural bus unit that takes offered messages after a set stall.
module ire_bus_model
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_msg_valid,
   input wire logic [7:0] i_stall,
   input wire logic i_accept,
   output logic o_msg_sent,
   output logic o_msg_accepted
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_r;
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wait_r <= 8'h00;
         o_msg_sent <= 1'b0;
         o_msg_accepted <= 1'b0;
      end
      else if (i_msg_valid && !o_msg_sent && wait_r == i_stall)
      begin
         wait_r <= 8'h00;
         o_msg_sent <= 1'b1;
         o_msg_accepted <= i_accept;
      end
      else
      begin
         // Outside a send the accept line carries junk on purpose.
         o_msg_sent <= 1'b0;
         o_msg_accepted <= !i_accept;
         if (i_msg_valid && !o_msg_sent)
            wait_r <= wait_r + 8'h01;
      end
   end
endmodule

/* File: ire_checker.sv */
// Concurrent checks on the ports of the redirection entry block.
module ire_checker
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ire_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic o_msg_valid,
   input wire logic i_msg_sent,
   input wire logic [ire_pkg::PIN_IDX_W-1:0] o_msg_pin,
   input wire logic [7:0] o_msg_dest,
   input wire logic o_msg_logical,
   input wire logic [2:0] o_msg_mode,
   input wire logic [7:0] o_msg_vector
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   sequence offer_wait_s;
      o_msg_valid && !i_msg_sent;
   endsequence
   sequence offer_end_s;
      o_msg_valid && i_msg_sent ##1 !o_msg_valid;
   endsequence
   offer_hold_a: assert property (offer_wait_s |=> o_msg_valid)
      else $error("offer dropped unsent");
   offer_close_a: assert property (o_msg_valid && i_msg_sent |-> offer_end_s)
      else $error("offer stays after send");
   msg_stable_a: assert property (offer_wait_s |=>
      $stable({o_msg_pin, o_msg_dest, o_msg_logical, o_msg_mode, o_msg_vector}))
      else $error("message changed while offered");
   phys_dest_a: assert property (o_msg_valid && !o_msg_logical |-> o_msg_dest[7:4] == 4'h0)
      else $error("physical target too wide");
   pin_range_a: assert property (o_msg_valid |-> o_msg_pin < ire_pkg::NUM_PINS)
      else $error("pin out of range");
   rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
      else $error("read data outside window");
   eoi_read_a: assert property (i_rd && i_addr == ire_pkg::ADDR_EOI_CLEAR |=> !(|o_rdata))
      else $error("clear register readable");
   hole_read_a: assert property (i_rd && i_addr > ire_pkg::ADDR_EOI_CLEAR |=> !(|o_rdata))
      else $error("unmapped read not zero");
endmodule

/* File: ire_pin_sync.sv */
// Two-flop synchroniser and polarity correction for one interrupt pin.
module ire_pin_sync
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_pin,
   input wire logic i_active_low,
   output logic o_active
);
   logic meta_r;
   logic sync_r;
   logic meta_nxt;
   logic sync_nxt;

   always_comb
   begin
      meta_nxt = i_pin;
      sync_nxt = meta_r;
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_active = sync_r ^ i_active_low;
endmodule

/* File: ire_pkg.sv */
// Package of constants and types for the interrupt redirection entry block.
package ire_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int NUM_PINS = 24;
   localparam int ENTRY_W = 64;
   localparam int PIN_IDX_W = 5;
   localparam int ADDR_W = 8;
   // ------------------------------------------------------------
   // Register map (word offsets on the plain register port)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_EOI_CLEAR = 8'h_40;
   localparam logic [7:0] ADDR_ENTRY_BASE = 8'h_10;
   localparam logic [7:0] ADDR_ENTRY_LAST = 8'h_3F;
   // ------------------------------------------------------------
   // Entry field positions
   // ------------------------------------------------------------
   localparam int F_DEST_HI = 63;
   localparam int F_DEST_LO = 56;
   localparam int F_PHYS_HI = 59;
   localparam int F_MASK = 16;
   localparam int F_TRIG = 15;
   localparam int F_RACC = 14;
   localparam int F_POL = 13;
   localparam int F_DSTAT = 12;
   localparam int F_DMODE_BIT = 11;
   localparam int F_DELIV_HI = 10;
   localparam int F_DELIV_LO = 8;
   localparam int F_VEC_HI = 7;
   // Software-writable bits of the low half: 16, 15, 13, 11:0.
   localparam logic [31:0] LO_WR_MASK = 32'h_0001_AFFF;
   // Mask set, all else zero at reset.
   localparam logic [63:0] ENTRY_RESET = 64'h_0000_0000_0001_0000;
   // ------------------------------------------------------------
   // Delivery modes
   // ------------------------------------------------------------
   localparam logic [2:0] DM_FIXED = 3'h_0;
   localparam logic [2:0] DM_LOWEST = 3'h_1;
   localparam logic [2:0] DM_SMI = 3'h_2;
   localparam logic [2:0] DM_NMI = 3'h_4;
   localparam logic [2:0] DM_INIT = 3'h_5;
   localparam logic [2:0] DM_EXTCTL = 3'h_7;
endpackage

/* File: ire_scan_arb.sv */
// Round-robin scanner that picks the next pin requesting delivery.
module ire_scan_arb
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ire_pkg::NUM_PINS-1:0] i_req,
   input wire logic i_advance,
   output logic [ire_pkg::PIN_IDX_W-1:0] o_index,
   output logic o_hit
);
   logic [ire_pkg::PIN_IDX_W-1:0] cnt_r;
   logic [ire_pkg::PIN_IDX_W-1:0] cnt_nxt;

   // The loop count walks every entry in turn; a request is offered when it is reached.
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (!(i_req[cnt_r] && !i_advance))
      begin
         if (cnt_r == ire_pkg::PIN_IDX_W'(ire_pkg::NUM_PINS - 1))
            cnt_nxt = '0;
         else
            cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

   assign o_index = cnt_r;
   assign o_hit = i_req[cnt_r];
endmodule

/* File: ire_top.sv */
// Redirection entry table that turns interrupt pin activity into delivery messages.
//
// Behaviour
// - Physical mode sends entry bits 59:56 as the target identifier.
// - Logical mode sends entry bits 63:56 as a processor set address.
// - Unmasked entry delivers a message for each qualifying edge or level.
// - Masked entry neither delivers nor holds interrupts pending.
// - Setting the mask does not recall an already accepted interrupt.
// - Bit 15 selects edge (0) or level (1) triggering.
// - Level entries set the accepted flag on acceptance, clear it on end message.
// - Bit 13 selects active high (0) or active low (1) pin.
// - Bit 12 is read-only delivery status, 1 while a message waits.
// - Bit 11 selects physical (0) or logical (1) destination matching.
// - Mode 000 is fixed delivery on the maskable line, any trigger.
// - Mode 001 targets the lowest priority listed core, any trigger.
// - Mode 100 drives the non-maskable line as edge, never sets accepted flag.
// - Level-mode non-maskable or init entries resend each time the scan returns.
// - Mode 101 drives init as edge and never sets accepted flag.
// - Mode 111 flags external controller origin; entry must be edge triggered.
// - After an edge, further edges are ignored until the send is confirmed.
// - A write to the end clear register clears matching accepted flags.
// - One 64-bit entry per pin, accessed as two 32-bit halves.
//
// The plain strobed port and the address map were left to the implementer.
module ire_top
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ire_pkg::NUM_PINS-1:0] i_irq_pin,
   input wire logic [ire_pkg::ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_msg_valid,
   input wire logic i_msg_sent,
   input wire logic i_msg_accepted,
   input wire logic i_eoi_valid,
   input wire logic [7:0] i_eoi_vector,
   output logic [ire_pkg::PIN_IDX_W-1:0] o_msg_pin,
   output logic [7:0] o_msg_dest,
   output logic o_msg_logical,
   output logic [2:0] o_msg_mode,
   output logic [7:0] o_msg_vector,
   output logic o_msg_level
);
   localparam int N = ire_pkg::NUM_PINS;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND} ire_state_t;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [63:0] entry_r [N];
   logic [63:0] entry_nxt [N];
   logic [N-1:0] pend_r;
   logic [N-1:0] pend_nxt;
   logic [N-1:0] prev_r;
   logic [N-1:0] prev_nxt;
   logic [N-1:0] active;
   logic [N-1:0] req;
   ire_state_t state_r;
   ire_state_t state_nxt;
   logic [ire_pkg::PIN_IDX_W-1:0] cur_r;
   logic [ire_pkg::PIN_IDX_W-1:0] cur_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [7:0] dest_r;
   logic [7:0] dest_nxt;
   logic logical_r;
   logic logical_nxt;
   logic [2:0] mode_r;
   logic [2:0] mode_nxt;
   logic [7:0] vec_r;
   logic [7:0] vec_nxt;
   logic level_r;
   logic level_nxt;
   logic [ire_pkg::PIN_IDX_W-1:0] scan_idx;
   logic scan_hit;
   logic take;
   logic [5:0] wr_word;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   generate
      for (genvar g = 0; g < N; g++)
      begin : g_pin
         ire_pin_sync u_sync
         (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .i_pin(i_irq_pin[g]),
            .i_active_low(entry_r[g][ire_pkg::F_POL]),
            .o_active(active[g])
         );
      end
   endgenerate

   // Level handling applies only to modes that are not forced to edge.
   function automatic logic is_level(input logic [63:0] e);
      logic [2:0] dm;
      dm = e[ire_pkg::F_DELIV_HI:ire_pkg::F_DELIV_LO];
      is_level = e[ire_pkg::F_TRIG] && (dm != ire_pkg::DM_NMI) && (dm != ire_pkg::DM_INIT);
   endfunction

   // ------------------------------------------------------------
   // Request generation
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         logic [63:0] e;
         logic nmi_lvl;
         e = entry_r[i];
         nmi_lvl = e[ire_pkg::F_TRIG] && !is_level(e);
         req[i] = !e[ire_pkg::F_MASK] &&
                  (pend_r[i] ||
                   (is_level(e) && active[i] && !e[ire_pkg::F_RACC]) ||
                   (nmi_lvl && active[i]));
      end
   end

   // ------------------------------------------------------------
   // Entry scanner
   // ------------------------------------------------------------
   ire_scan_arb u_arb
   (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_req(req),
      .i_advance(state_r == ST_SEND),
      .o_index(scan_idx),
      .o_hit(scan_hit)
   );

   // The scanner parks on a requesting pin while idle, so a take is never missed.
   assign take = (state_r == ST_IDLE) && scan_hit;
   assign wr_word = 6'(i_addr - ire_pkg::ADDR_ENTRY_BASE);

   // ------------------------------------------------------------
   // Entry table, pending and edge capture
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         logic [63:0] e;
         logic was_active;
         logic eoi_hit;
         e = entry_r[i];
         eoi_hit = (i_wr && i_addr == ire_pkg::ADDR_EOI_CLEAR
                    && i_wdata[ire_pkg::F_VEC_HI:0] == e[ire_pkg::F_VEC_HI:0])
                   || (i_eoi_valid && i_eoi_vector == e[ire_pkg::F_VEC_HI:0]);
         // The edge memory keeps the raw pin level, so a polarity write alone is no edge.
         was_active = prev_r[i] ^ e[ire_pkg::F_POL];
         prev_nxt[i] = active[i] ^ e[ire_pkg::F_POL];
         pend_nxt[i] = pend_r[i];
         // The send confirmation clears first, so an edge in that same cycle is kept.
         if (state_r == ST_SEND && i_msg_sent && cur_r == ire_pkg::PIN_IDX_W'(i))
            pend_nxt[i] = 1'b0;
         if (!is_level(e) && active[i] && !was_active && !e[ire_pkg::F_MASK])
            pend_nxt[i] = 1'b1;
         if (e[ire_pkg::F_MASK])
            pend_nxt[i] = 1'b0;
         if (i_wr && i_addr >= ire_pkg::ADDR_ENTRY_BASE && i_addr <= ire_pkg::ADDR_ENTRY_LAST
             && wr_word[5:1] == ire_pkg::PIN_IDX_W'(i))
         begin
            if (wr_word[0])
               e[63:32] = i_wdata;
            else
               e[31:0] = (i_wdata & ire_pkg::LO_WR_MASK) | (e[31:0] & ~ire_pkg::LO_WR_MASK);
         end
         if (eoi_hit)
            e[ire_pkg::F_RACC] = 1'b0;
         if (state_r == ST_SEND && i_msg_sent && i_msg_accepted && level_r
             && cur_r == ire_pkg::PIN_IDX_W'(i))
            e[ire_pkg::F_RACC] = 1'b1;
         e[ire_pkg::F_DSTAT] = pend_nxt[i] || (state_r == ST_SEND && cur_r == ire_pkg::PIN_IDX_W'(i)
                                               && !i_msg_sent);
         entry_nxt[i] = e;
      end
   end

   // ------------------------------------------------------------
   // Message sequencer and read port
   // ------------------------------------------------------------
   always_comb
   begin
      logic [63:0] s;
      s = entry_r[scan_idx];
      state_nxt = state_r;
      cur_nxt = cur_r;
      dest_nxt = dest_r;
      logical_nxt = logical_r;
      mode_nxt = mode_r;
      vec_nxt = vec_r;
      level_nxt = level_r;
      rdata_nxt = 32'h_0000_0000;
      if (take)
      begin
         state_nxt = ST_SEND;
         cur_nxt = scan_idx;
         logical_nxt = s[ire_pkg::F_DMODE_BIT];
         if (s[ire_pkg::F_DMODE_BIT])
            dest_nxt = s[ire_pkg::F_DEST_HI:ire_pkg::F_DEST_LO];
         else
            dest_nxt = {4'h_0, s[ire_pkg::F_PHYS_HI:ire_pkg::F_DEST_LO]};
         mode_nxt = s[ire_pkg::F_DELIV_HI:ire_pkg::F_DELIV_LO];
         vec_nxt = s[ire_pkg::F_VEC_HI:0];
         // The trigger kind is latched here so acceptance follows the entry as sent.
         // level qualifies setting the accepted flag
         level_nxt = is_level(s);
      end
      else if (state_r == ST_SEND && i_msg_sent)
         state_nxt = ST_IDLE;
      if (i_rd)
      begin
         if (i_addr >= ire_pkg::ADDR_ENTRY_BASE && i_addr <= ire_pkg::ADDR_ENTRY_LAST)
         begin
            if (wr_word[0])
               rdata_nxt = entry_r[wr_word[5:1]][63:32];
            else
               rdata_nxt = entry_r[wr_word[5:1]][31:0];
         end
         else
            rdata_nxt = 32'h_0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < N; i++)
            entry_r[i] <= ire_pkg::ENTRY_RESET;
         pend_r <= '0;
         prev_r <= '0;
         state_r <= ST_IDLE;
         cur_r <= '0;
         rdata_r <= 32'h_0000_0000;
         dest_r <= 8'h_00;
         logical_r <= 1'b0;
         mode_r <= 3'h_0;
         vec_r <= 8'h_00;
         level_r <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < N; i++)
            entry_r[i] <= entry_nxt[i];
         pend_r <= pend_nxt;
         prev_r <= prev_nxt;
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         rdata_r <= rdata_nxt;
         dest_r <= dest_nxt;
         logical_r <= logical_nxt;
         mode_r <= mode_nxt;
         vec_r <= vec_nxt;
         level_r <= level_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_rdata = rdata_r;
   assign o_msg_valid = (state_r == ST_SEND);
   assign o_msg_pin = cur_r;
   assign o_msg_dest = dest_r;
   assign o_msg_logical = logical_r;
   assign o_msg_mode = mode_r;
   assign o_msg_vector = vec_r;
   assign o_msg_level = level_r;
endmodule

/* File: tb.sv */
// Testbench for the redirection entry block.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [ire_pkg::NUM_PINS-1:0] i_irq_pin = '0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_eoi_valid = 1'b0;
   logic [7:0] i_eoi_vector = 8'h00;
   logic [7:0] stall = 8'h02;
   logic accept = 1'b0;
   logic [31:0] o_rdata;
   logic o_msg_valid;
   logic i_msg_sent;
   logic i_msg_accepted;
   logic [4:0] o_msg_pin;
   logic [7:0] o_msg_dest;
   logic o_msg_logical;
   logic [2:0] o_msg_mode;
   logic [7:0] o_msg_vector;
   logic o_msg_level;
   logic [31:0] cap = 32'h0000_0000;
   logic [2:0] m;
   int err_count = 0;
   int tests_run = 0;
   int msg_cnt = 0;
   int mark = 0;
   always #5 i_mclk = ~i_mclk;
   ire_top dut (.i_mclk, .i_rst, .i_irq_pin, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_msg_valid, .i_msg_sent, .i_msg_accepted, .i_eoi_valid, .i_eoi_vector, .o_msg_pin,
      .o_msg_dest, .o_msg_logical, .o_msg_mode, .o_msg_vector, .o_msg_level);
   ire_bus_model far_end (.i_mclk, .i_rst, .i_msg_valid(o_msg_valid), .i_stall(stall),
      .i_accept(accept), .o_msg_sent(i_msg_sent), .o_msg_accepted(i_msg_accepted));
   always @(posedge i_mclk)
   begin
      if (o_msg_valid && i_msg_sent)
      begin
         msg_cnt <= msg_cnt + 1;
         cap <= {3'h0, o_msg_level, o_msg_logical, o_msg_mode, 3'h0, o_msg_pin, o_msg_dest,
                 o_msg_vector};
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, exp);
      @(posedge i_mclk);
   endtask
   task automatic end_of_interrupt_msg(input logic [7:0] v);
      i_eoi_vector <= v;
      i_eoi_valid <= 1'b1;
      @(posedge i_mclk);
      i_eoi_valid <= 1'b0;
   endtask
   // Counts messages since the previous call; zero waits out the whole span.
   task automatic expect_cnt(input int n, input int cyc);
      repeat (cyc)
      begin
         @(posedge i_mclk);
         if (n > 0 && msg_cnt - mark >= n)
            break;
      end
      check(msg_cnt - mark, n);
      mark = msg_cnt;
   endtask
   task automatic summarize;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      summarize();
   end
   initial
   begin
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      rd(8'h10, 32'h0001_0000);
      rd(8'h11, 32'h0000_0000);
      rd(8'h3E, 32'h0001_0000);
      wr(8'h12, 32'hFFFF_FFFF);
      rd(8'h12, ire_pkg::LO_WR_MASK);
      rd(8'h41, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
      wr(8'h11, 32'h0500_0000);
      wr(8'h10, 32'h0000_0031);
      stall <= 8'h14;
      i_irq_pin[0] <= 1'b1;
      repeat (60)
      begin
         @(posedge i_mclk);
         #1;
         if (o_msg_valid === 1'b1)
            break;
      end
      check({o_msg_valid, o_msg_logical, o_msg_mode, o_msg_pin}, 32'h0000_0200);
      check({o_msg_dest, o_msg_vector}, 32'h0000_0531);
      @(posedge i_mclk);
      rd(8'h10, 32'h0000_1031);
      i_irq_pin[0] <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_irq_pin[0] <= 1'b1;
      expect_cnt(1, 80);
      expect_cnt(0, 80);
      rd(8'h10, 32'h0000_0031);
      stall <= 8'h02;
      i_irq_pin[0] <= 1'b0;
      wr(8'h10, 32'h0001_0031);
      i_irq_pin[0] <= 1'b1;
      expect_cnt(0, 60);
      wr(8'h10, 32'h0000_0031);
      expect_cnt(0, 60);
      i_irq_pin[2] <= 1'b1;
      wr(8'h14, 32'h0000_2040);
      expect_cnt(0, 40);
      i_irq_pin[2] <= 1'b0;
      expect_cnt(1, 80);
      check(cap[20:16], 32'h0000_0002);
      accept <= 1'b1;
      wr(8'h17, 32'h0200_0000);
      wr(8'h16, 32'h0000_8055);
      i_irq_pin[3] <= 1'b1;
      expect_cnt(1, 80);
      check(cap[28], 32'h0000_0001);
      expect_cnt(0, 80);
      rd(8'h16, 32'h0000_C055);
      wr(8'h16, 32'h0001_8055);
      rd(8'h16, 32'h0001_C055);
      wr(8'h16, 32'h0000_8055);
      end_of_interrupt_msg(8'h55);
      expect_cnt(1, 80);
      i_irq_pin[3] <= 1'b0;
      repeat (4) @(posedge i_mclk);
      wr(8'h40, 32'h0000_0055);
      rd(8'h16, 32'h0000_8055);
      wr(8'h19, 32'hA500_0000);
      for (int k = 0; k < 6; k++)
      begin
         m = (k < 3) ? 3'(k) : 3'(k + 1);
         if (k == 5)
            m = ire_pkg::DM_EXTCTL;
         wr(8'h18, {20'h0_0000, 1'b1, m, (m == ire_pkg::DM_SMI) ? 8'h00 : 8'h60});
         i_irq_pin[4] <= 1'b1;
         expect_cnt(1, 80);
         check(cap[31:8], {12'h000, 1'b1, m, 8'h04, 8'hA5});
         i_irq_pin[4] <= 1'b0;
         repeat (4) @(posedge i_mclk);
      end
      wr(8'h1A, 32'h0000_8400);
      i_irq_pin[5] <= 1'b1;
      expect_cnt(2, 200);
      check(cap[28], 32'h0000_0000);
      i_irq_pin[5] <= 1'b0;
      repeat (60) @(posedge i_mclk);
      mark = msg_cnt;
      rd(8'h1A, 32'h0000_8400);
      summarize();
   end
endmodule
bind ire_top ire_checker chk (.i_mclk, .i_rst, .i_addr, .i_rd, .o_rdata, .o_msg_valid,
   .i_msg_sent, .o_msg_pin, .o_msg_dest, .o_msg_logical, .o_msg_mode, .o_msg_vector);
